/* File: csp_codec_map.svh */
`ifndef CSP_CODEC_MAP_SVH
`define CSP_CODEC_MAP_SVH

// ----------------------------------------------------------------------------
// Reset values of the divider registers
// ----------------------------------------------------------------------------
`define CSP_RST_DIV_A 5'h12
`define CSP_RST_DIV_B 6'h12
`define CSP_RST_ADJUST 6'h01

// ----------------------------------------------------------------------------
// Reset values of the control bits
// ----------------------------------------------------------------------------
`define CSP_RST_HP_INSERT 1'h1
`define CSP_RST_LOOPBACK 1'h0
`define CSP_RST_AUX_ENABLE 1'h0
`define CSP_RST_SYNC_MODE 1'h1
`define CSP_RST_GAIN 2'h3
`define CSP_RST_SINX 1'h0
`define CSP_RST_GP_OUT 1'h0

// ----------------------------------------------------------------------------
// Serial word fields and frame timing
// ----------------------------------------------------------------------------
`define CSP_LOW_CODE_SECONDARY 2'h3
`define CSP_SEC_TA_MSB 13
`define CSP_SEC_TA_LSB 9
`define CSP_SEC_RA_MSB 6
`define CSP_SEC_RA_LSB 2
`define CSP_SEC_HI6_MSB 14
`define CSP_SEC_HI6_LSB 9
`define CSP_SEC_LO6_MSB 7
`define CSP_SEC_LO6_LSB 2
`define CSP_CTRL_HP_POS 2
`define CSP_CTRL_LOOP_POS 3
`define CSP_CTRL_AUX_POS 4
`define CSP_CTRL_SYNC_POS 5
`define CSP_CTRL_GAIN_MSB 7
`define CSP_CTRL_GAIN_LSB 6
`define CSP_CTRL_SINX_POS 9
`define CSP_CTRL_GP10_POS 10
`define CSP_CTRL_GP11_POS 11
`define CSP_WORD_LAST_BIT 4'hF
`define CSP_BYTE_LAST_BIT 4'h7
`define CSP_GAP_SHIFTS 3'h4
`define CSP_SHIFT_DIV_LAST 2'h3
`define CSP_MIN_PRESCALE 7'h02

`endif

/* File: csp_pkg.sv */
package csp_pkg;

  // Control register bits set by a secondary word with low code 11.
  typedef struct packed {
    logic gpEleven;
    logic gpTen;
    logic sinxFilter;
    logic [1:0] gain;
    logic syncMode;
    logic auxEnable;
    logic loopback;
    logic hpInsert;
  } csp_ctrl_t;

  // Prescale load selection carried from a primary word to the dividers.
  typedef enum logic [1:0] {
    CSP_ADJ_NONE = 2'h0,
    CSP_ADJ_PLUS = 2'h1,
    CSP_ADJ_MINUS = 2'h2
  } csp_adj_t;

  // Serial frame sequencer states.
  typedef enum logic [4:0] {
    CSP_ST_IDLE = 5'h01,
    CSP_ST_SHIFT = 5'h02,
    CSP_ST_MID = 5'h04,
    CSP_ST_TAIL = 5'h08,
    CSP_ST_SGAP = 5'h10
  } csp_state_t;

endpackage

/* File: csp_rate_divider.sv */
`timescale 1ns/1ps
`include "csp_codec_map.svh"

module csp_rate_divider (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic [4:0] divA,
  input wire logic [5:0] periodAdjust,
  input wire logic [5:0] divB,
  input wire csp_pkg::csp_adj_t adjSel,
  input wire logic adjStrobe,
  output logic filterClk,
  output logic convStrobe
);
  import csp_pkg::*;

  logic [6:0] preCnt;
  logic [5:0] rateCnt;
  csp_adj_t pendingAdj;
  logic [6:0] baseLoad;
  logic [6:0] adjLoad;

  // Adjusted prescale load; clamped so a bad adjust cannot stall the counter.
  always_comb begin
    baseLoad = {2'h0, divA};
    adjLoad = baseLoad;
    if (pendingAdj == CSP_ADJ_PLUS) begin
      adjLoad = baseLoad + {periodAdjust[5], periodAdjust};
    end else if (pendingAdj == CSP_ADJ_MINUS) begin
      adjLoad = baseLoad - {periodAdjust[5], periodAdjust};
    end
    if ($signed(adjLoad) < $signed(`CSP_MIN_PRESCALE)) begin
      adjLoad = `CSP_MIN_PRESCALE;
    end
  end

  // Filter clock toggles every A master cycles, so it runs at clk over 2A.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      preCnt <= {2'h0, `CSP_RST_DIV_A};
      rateCnt <= `CSP_RST_DIV_B;
      filterClk <= 1'h0;
      convStrobe <= 1'h0;
      pendingAdj <= CSP_ADJ_NONE;
    end else if (ce) begin
      convStrobe <= 1'h0;
      if (adjStrobe) begin
        pendingAdj <= adjSel;
      end
      if (preCnt <= 7'h01) begin
        filterClk <= ~filterClk;
        preCnt <= baseLoad;
        if (filterClk) begin
          if (rateCnt <= 6'h01) begin
            rateCnt <= divB;
            convStrobe <= 1'h1;
            preCnt <= adjLoad;
            if (!adjStrobe) begin
              pendingAdj <= CSP_ADJ_NONE;
            end
          end else begin
            rateCnt <= rateCnt - 6'h01;
          end
        end
      end else begin
        preCnt <= preCnt - 7'h01;
      end
    end
  end

  rate_reload_a: assert property (@(posedge clk) disable iff (sys_rst)
    convStrobe |-> rateCnt == divB)
    else $error("Rate counter did not reload from the B divider.");

  adj_single_a: assert property (@(posedge clk) disable iff (sys_rst)
    (convStrobe && !$past(adjStrobe)) |-> pendingAdj == CSP_ADJ_NONE)
    else $error("Period adjust was kept past one conversion period.");

endmodule

/* File: csp_serial_port.sv */
`timescale 1ns/1ps
`include "csp_codec_map.svh"

// Functional notes
// - Word mode: frame sync low, exactly sixteen bits shifted, frame sync high.
// - Word mode: end-of-data pulses low for one shift clock after the word.
// - Byte mode: frame sync low, first byte shifted, then end-of-data low.
// - Between bytes frame sync high four shift clocks; afterwards sync then EOD rise.
// - Filter clocks are master clock over twice the matching A divider.
// - Conversion rates are filter clocks over the matching B divider.
// - Receive high-pass filter clock runs at the ADC conversion rate.
// - Reset initialises every internal register including the control bits.
// - Reset loads A and B dividers with 0x12, period adjusts with 0x01.
// - Reset sets high-pass in, loopback off, aux off, sync, gain one.
// - Dual-word mode sends ADC word under receive sync, then aux data.
// - Receive sync idle during secondary, aux sync idle during primary transfers.
// - Output word carries 14-bit ADC result MSB first, two low bits zero.
// - Byte mode sends the same word as two bytes, same order.
// - Every primary word loads bits fifteen to two into the DAC register.
// - Rate counters always reload from B; adjust codes alter only prescale load.
// - Low code 01 loads A plus signed adjust for the next period.
// - Low code 10 loads A minus signed adjust for the next period.
// - Low code 11 starts secondary four shift clocks after primary, sync high.
// - Secondary uses primary timing and sits between primaries; no DAC skip.
// - Dual-word mode routes aux serial input to serial output in secondary.
// - Control bit D5 clear makes receive use its own A and B dividers.
// - Secondary low code 11 updates the control bits D2 through D11, except D8.
module csp_serial_port (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic byteMode,
  input wire logic dualWordMode,
  input wire logic serial_data_in,
  input wire logic aux_serial_in,
  input wire logic [13:0] adcResult,
  output logic shiftClk,
  output logic serial_data_out,
  output logic tx_frame_sync,
  output logic rx_frame_sync,
  output logic aux_frame_sync,
  output logic tx_end_of_data,
  output logic rx_end_of_data,
  output logic [13:0] dacData,
  output csp_pkg::csp_ctrl_t ctrl,
  output logic dacFilterClk,
  output logic adcFilterClk,
  output logic dacConvStrobe,
  output logic adcConvStrobe,
  output logic hpFilterClk
);
  import csp_pkg::*;

  // --------------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------------
  csp_state_t state;
  logic [1:0] tickCnt;
  logic shiftTick;
  logic [3:0] bitCnt;
  logic [2:0] gapCnt;
  logic isSecondary;
  logic firstByte;
  logic byteLatched;
  logic rxActive;
  logic priPending;
  logic rxPending;
  logic [15:0] txShift;
  logic [15:0] rxShift;
  logic [13:0] adcSample;
  logic [4:0] tx_divider_a;
  logic [4:0] rx_divider_a;
  logic [5:0] tx_divider_b;
  logic [5:0] rx_divider_b;
  logic [5:0] tx_period_adjust;
  logic [5:0] rx_period_adjust;
  logic adjStrobe;
  csp_adj_t adjSel;
  logic rxDivFilterClk;
  logic rxDivConv;
  logic txConv;
  logic txFilter;
  logic startPri;
  logic wordDone;

  // --------------------------------------------------------------------------
  // Shift clock
  // --------------------------------------------------------------------------
  // Master clock over four; frame logic moves only on the tick.
  assign shiftTick = ce && (tickCnt == `CSP_SHIFT_DIV_LAST);
  assign startPri = shiftTick && (state == CSP_ST_IDLE) && priPending;
  assign wordDone = shiftTick && (state == CSP_ST_TAIL);

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      tickCnt <= 2'h0;
      shiftClk <= 1'h0;
    end else if (ce) begin
      tickCnt <= tickCnt + 2'h1;
      shiftClk <= tickCnt[1];
    end
  end

  // --------------------------------------------------------------------------
  // Conversion timing
  // --------------------------------------------------------------------------
  csp_rate_divider txDiv (
    .clk(clk),
    .sys_rst(sys_rst),
    .ce(ce),
    .divA(tx_divider_a),
    .periodAdjust(tx_period_adjust),
    .divB(tx_divider_b),
    .adjSel(adjSel),
    .adjStrobe(adjStrobe),
    .filterClk(txFilter),
    .convStrobe(txConv)
  );

  csp_rate_divider rxDiv (
    .clk(clk),
    .sys_rst(sys_rst),
    .ce(ce),
    .divA(rx_divider_a),
    .periodAdjust(rx_period_adjust),
    .divB(rx_divider_b),
    .adjSel(adjSel),
    .adjStrobe(adjStrobe),
    .filterClk(rxDivFilterClk),
    .convStrobe(rxDivConv)
  );

  // In synchronous mode the receive side follows the transmit dividers.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      dacFilterClk <= 1'h0;
      adcFilterClk <= 1'h0;
      dacConvStrobe <= 1'h0;
      adcConvStrobe <= 1'h0;
      hpFilterClk <= 1'h0;
    end else if (ce) begin
      dacFilterClk <= txFilter;
      dacConvStrobe <= txConv;
      adcFilterClk <= ctrl.syncMode ? txFilter : rxDivFilterClk;
      adcConvStrobe <= ctrl.syncMode ? txConv : rxDivConv;
      hpFilterClk <= ctrl.syncMode ? txConv : rxDivConv;
    end
  end

  // --------------------------------------------------------------------------
  // Conversion bookkeeping
  // --------------------------------------------------------------------------
  // A new event in the cycle its flag is consumed keeps the flag set.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      priPending <= 1'h0;
      rxPending <= 1'h0;
      adcSample <= 14'h0000;
    end else if (ce) begin
      priPending <= dacConvStrobe | (priPending & ~startPri);
      rxPending <= adcConvStrobe | (rxPending & ~startPri);
      if (adcConvStrobe) begin
        // Loopback feeds the DAC code straight back as the next ADC result.
        adcSample <= ctrl.loopback ? dacData : adcResult;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Frame sequencer
  // --------------------------------------------------------------------------
  // One shift engine serves both directions; the receive sync only drops
  // when a fresh ADC result exists, so async rates never resend a sample.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state <= CSP_ST_IDLE;
      bitCnt <= 4'h0;
      gapCnt <= 3'h0;
      isSecondary <= 1'h0;
      firstByte <= 1'h0;
      byteLatched <= 1'h0;
      rxActive <= 1'h0;
      txShift <= 16'h0000;
      rxShift <= 16'h0000;
      serial_data_out <= 1'h0;
      tx_frame_sync <= 1'h1;
      rx_frame_sync <= 1'h1;
      aux_frame_sync <= 1'h1;
      tx_end_of_data <= 1'h1;
      rx_end_of_data <= 1'h1;
    end else if (shiftTick) begin
      unique case (state)
        CSP_ST_IDLE: begin
          if (priPending) begin
            state <= CSP_ST_SHIFT;
            bitCnt <= 4'h0;
            isSecondary <= 1'h0;
            firstByte <= 1'h1;
            byteLatched <= byteMode;
            rxActive <= rxPending;
            txShift <= {adcSample, 2'h0};
            serial_data_out <= adcSample[13];
            tx_frame_sync <= 1'h0;
            rx_frame_sync <= ~rxPending;
            aux_frame_sync <= 1'h1;
          end
        end
        CSP_ST_SHIFT: begin
          rxShift <= {rxShift[14:0], serial_data_in};
          txShift <= {txShift[14:0], 1'h0};
          bitCnt <= bitCnt + 4'h1;
          if (isSecondary) begin
            serial_data_out <= dualWordMode ? aux_serial_in : 1'h0;
          end else begin
            serial_data_out <= txShift[14];
          end
          if (byteLatched && firstByte && bitCnt == `CSP_BYTE_LAST_BIT) begin
            state <= CSP_ST_MID;
            gapCnt <= 3'h1;
            firstByte <= 1'h0;
            tx_frame_sync <= 1'h1;
            rx_frame_sync <= 1'h1;
            aux_frame_sync <= 1'h1;
            tx_end_of_data <= 1'h0;
            rx_end_of_data <= ~rxActive | isSecondary;
          end else if (bitCnt == `CSP_WORD_LAST_BIT) begin
            state <= CSP_ST_TAIL;
            tx_frame_sync <= 1'h1;
            rx_frame_sync <= 1'h1;
            aux_frame_sync <= 1'h1;
            if (!byteLatched) begin
              tx_end_of_data <= 1'h0;
              rx_end_of_data <= ~rxActive | isSecondary;
            end
          end
        end
        CSP_ST_MID: begin
          // Sync stays high four shift clocks between the two bytes.
          if (gapCnt == `CSP_GAP_SHIFTS) begin
            state <= CSP_ST_SHIFT;
            tx_frame_sync <= 1'h0;
            rx_frame_sync <= ~rxActive | isSecondary;
            aux_frame_sync <= ~(isSecondary & dualWordMode);
          end else begin
            gapCnt <= gapCnt + 3'h1;
          end
        end
        CSP_ST_TAIL: begin
          tx_end_of_data <= 1'h1;
          rx_end_of_data <= 1'h1;
          if (!isSecondary && rxShift[1:0] == `CSP_LOW_CODE_SECONDARY) begin
            state <= CSP_ST_SGAP;
            gapCnt <= 3'h2;
          end else begin
            state <= CSP_ST_IDLE;
          end
        end
        CSP_ST_SGAP: begin
          // Transmit sync held high through the gap before the secondary.
          if (gapCnt == `CSP_GAP_SHIFTS) begin
            state <= CSP_ST_SHIFT;
            bitCnt <= 4'h0;
            isSecondary <= 1'h1;
            firstByte <= 1'h1;
            byteLatched <= byteMode;
            serial_data_out <= dualWordMode ? aux_serial_in : 1'h0;
            tx_frame_sync <= 1'h0;
            rx_frame_sync <= 1'h1;
            aux_frame_sync <= ~dualWordMode;
          end else begin
            gapCnt <= gapCnt + 3'h1;
          end
        end
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Word decode
  // --------------------------------------------------------------------------
  // Primary words always update the DAC and pass the adjust code on.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      dacData <= 14'h0000;
      adjStrobe <= 1'h0;
      adjSel <= CSP_ADJ_NONE;
    end else if (ce) begin
      adjStrobe <= 1'h0;
      if (wordDone && !isSecondary) begin
        dacData <= rxShift[15:2];
        adjStrobe <= 1'h1;
        unique case (rxShift[1:0])
          2'h1: adjSel <= CSP_ADJ_PLUS;
          2'h2: adjSel <= CSP_ADJ_MINUS;
          default: adjSel <= CSP_ADJ_NONE;
        endcase
      end
    end
  end

  // Secondary words program dividers, adjusts or control bits.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      tx_divider_a <= `CSP_RST_DIV_A;
      rx_divider_a <= `CSP_RST_DIV_A;
      tx_divider_b <= `CSP_RST_DIV_B;
      rx_divider_b <= `CSP_RST_DIV_B;
      tx_period_adjust <= `CSP_RST_ADJUST;
      rx_period_adjust <= `CSP_RST_ADJUST;
      ctrl.hpInsert <= `CSP_RST_HP_INSERT;
      ctrl.loopback <= `CSP_RST_LOOPBACK;
      ctrl.auxEnable <= `CSP_RST_AUX_ENABLE;
      ctrl.syncMode <= `CSP_RST_SYNC_MODE;
      ctrl.gain <= `CSP_RST_GAIN;
      ctrl.sinxFilter <= `CSP_RST_SINX;
      ctrl.gpTen <= `CSP_RST_GP_OUT;
      ctrl.gpEleven <= `CSP_RST_GP_OUT;
    end else if (ce && wordDone && isSecondary) begin
      unique case (rxShift[1:0])
        2'h0: begin
          tx_divider_a <= rxShift[`CSP_SEC_TA_MSB:`CSP_SEC_TA_LSB];
          rx_divider_a <= rxShift[`CSP_SEC_RA_MSB:`CSP_SEC_RA_LSB];
        end
        2'h1: begin
          tx_period_adjust <= rxShift[`CSP_SEC_HI6_MSB:`CSP_SEC_HI6_LSB];
          rx_period_adjust <= rxShift[`CSP_SEC_LO6_MSB:`CSP_SEC_LO6_LSB];
        end
        2'h2: begin
          tx_divider_b <= rxShift[`CSP_SEC_HI6_MSB:`CSP_SEC_HI6_LSB];
          rx_divider_b <= rxShift[`CSP_SEC_LO6_MSB:`CSP_SEC_LO6_LSB];
        end
        2'h3: begin
          ctrl.hpInsert <= rxShift[`CSP_CTRL_HP_POS];
          ctrl.loopback <= rxShift[`CSP_CTRL_LOOP_POS];
          ctrl.auxEnable <= rxShift[`CSP_CTRL_AUX_POS];
          ctrl.syncMode <= rxShift[`CSP_CTRL_SYNC_POS];
          ctrl.gain <= rxShift[`CSP_CTRL_GAIN_MSB:`CSP_CTRL_GAIN_LSB];
          ctrl.sinxFilter <= rxShift[`CSP_CTRL_SINX_POS];
          ctrl.gpTen <= rxShift[`CSP_CTRL_GP10_POS];
          ctrl.gpEleven <= rxShift[`CSP_CTRL_GP11_POS];
        end
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  sequence wordEnds;
    $rose(tx_frame_sync) && !byteLatched;
  endsequence

  sequence secondaryOpens;
    $fell(tx_frame_sync) && isSecondary && bitCnt == 4'h0;
  endsequence

  sequence eodPulse;
    !tx_end_of_data [*3] ##1 (!tx_end_of_data && shiftTick) ##1 tx_end_of_data;
  endsequence

  word_length_a: assert property (@(posedge clk) disable iff (sys_rst)
    wordEnds |-> $past(bitCnt) == `CSP_WORD_LAST_BIT && state == CSP_ST_TAIL)
    else $error("Word frame did not span sixteen bits.");

  eod_width_a: assert property (@(posedge clk) disable iff (sys_rst)
    wordEnds |-> eodPulse)
    else $error("Word end-of-data pulse width wrong.");

  byte_gap_a: assert property (@(posedge clk) disable iff (sys_rst)
    state == CSP_ST_MID |-> tx_frame_sync && !tx_end_of_data)
    else $error("Sync or end-of-data wrong between bytes.");

  rx_idle_sec_a: assert property (@(posedge clk) disable iff (sys_rst)
    isSecondary |-> rx_frame_sync)
    else $error("Receive sync asserted during secondary.");

  aux_idle_pri_a: assert property (@(posedge clk) disable iff (sys_rst)
    (state != CSP_ST_IDLE && !isSecondary) |-> aux_frame_sync)
    else $error("Aux sync asserted during primary.");

  out_lsb_zero_a: assert property (@(posedge clk) disable iff (sys_rst)
    (state == CSP_ST_SHIFT && !isSecondary) |-> txShift[1:0] == 2'h0)
    else $error("Output word low bits not zero.");

  sec_gap_high_a: assert property (@(posedge clk) disable iff (sys_rst)
    secondaryOpens |-> $past(state) == CSP_ST_SGAP && $past(tx_frame_sync))
    else $error("Secondary began without the held-high gap.");

  dac_load_a: assert property (@(posedge clk) disable iff (sys_rst)
    (wordDone && !isSecondary) |=> {dacData, 2'h0} == ($past(rxShift) & 16'hFFFC))
    else $error("DAC register missed the primary word.");

  hp_rate_a: assert property (@(posedge clk) disable iff (sys_rst)
    (ce && ctrl.syncMode && $past(ctrl.syncMode) && txConv) |=> hpFilterClk)
    else $error("High-pass clock not at conversion rate.");

endmodule

/* File: csp_host_model.sv */
`timescale 1ns/1ps

// ----------------------------------------------------------------------------
// Host serial port model
// ----------------------------------------------------------------------------
module csp_host_model (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic txSync,
  input wire logic dataOut,
  output logic dataIn
);
  logic [15:0] txQ[$];
  logic [15:0] word;
  logic [15:0] rxWord;
  logic [15:0] lastRx;
  logic prevSync;
  int ptr;
  int cnt;

  // One bit moves every fourth clock while the frame sync is low; a word spans two syncs in byte mode.
  // Outside frames the data line toggles, so a stray sample never sees a stale bit.
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      dataIn <= 1'b0;
      prevSync = 1'b1;
      ptr = -1;
      cnt = 0;
      lastRx = 16'h0000;
    end else begin
      if (!txSync && prevSync) begin
        cnt = 0;
        if (ptr < 0) begin
          word = (txQ.size() > 0) ? txQ.pop_front() : 16'h0000;
          ptr = 15;
        end
      end
      if (!txSync && ptr >= 0 && cnt % 4 == 0) begin
        dataIn <= word[ptr];
        rxWord[ptr] = dataOut;
        if (ptr == 0) lastRx = rxWord;
        ptr--;
      end else if (txSync) begin
        dataIn <= ~dataIn;
      end
      cnt++;
      prevSync = txSync;
    end
  end
endmodule

/* File: tb_top.sv */
`timescale 1ns/1ps

module tb_top;
  import csp_pkg::*;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic ce = 1'b1;
  logic byteMode = 1'b0;
  logic dualWordMode = 1'b0;
  logic auxIn = 1'b1;
  logic [13:0] adcResult = 14'h2A5C;
  logic serialIn, shiftClk, serialOut, txSync, rxSync, auxSync, txEod, rxEod;
  logic [13:0] dacData;
  csp_ctrl_t ctrl;
  logic dacFilterClk, adcFilterClk, dacConvStrobe, adcConvStrobe, hpFilterClk;
  int fail_count = 0;
  int check_count = 0;
  time tRise;

  // ----------------------------------------------------------------------------
  // Clock, device and host
  // ----------------------------------------------------------------------------
  always #25 clk = ~clk;

  csp_serial_port u_dut (.clk(clk), .sys_rst(sys_rst), .ce(ce), .byteMode(byteMode),
    .dualWordMode(dualWordMode), .serial_data_in(serialIn), .aux_serial_in(auxIn),
    .adcResult(adcResult), .shiftClk(shiftClk), .serial_data_out(serialOut),
    .tx_frame_sync(txSync), .rx_frame_sync(rxSync), .aux_frame_sync(auxSync),
    .tx_end_of_data(txEod), .rx_end_of_data(rxEod), .dacData(dacData), .ctrl(ctrl),
    .dacFilterClk(dacFilterClk), .adcFilterClk(adcFilterClk), .dacConvStrobe(dacConvStrobe),
    .adcConvStrobe(adcConvStrobe), .hpFilterClk(hpFilterClk));

  csp_host_model u_host (.clk(clk), .sys_rst(sys_rst), .txSync(txSync), .dataOut(serialOut),
    .dataIn(serialIn));

  // ----------------------------------------------------------------------------
  // Shared helpers
  // ----------------------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic test_done();
    if (fail_count == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // Counts clocks while the transmit sync holds a level; bounded so a stuck sync cannot hang.
  task automatic runLen(input logic lvl, output int n);
    n = 0;
    while (txSync === lvl && n < 3000) begin
      @(posedge clk);
      #2;
      n++;
    end
  endtask

  function automatic logic pick(input int w);
    case (w)
      0: return dacConvStrobe;
      1: return adcConvStrobe;
      2: return hpFilterClk;
      default: return dacFilterClk;
    endcase
  endfunction

  // Clocks between two rising edges of the chosen timing output.
  task automatic period(input int w, input int exp);
    int n, t;
    logic p;
    n = -1;
    t = 0;
    p = pick(w);
    while (n < exp + 1 && t < 4000) begin
      @(posedge clk);
      #2;
      t++;
      if (n >= 0) n++;
      if (pick(w) === 1'b1 && p === 1'b0) begin
        if (n > 0) break;
        n = 0;
      end
      p = pick(w);
    end
    check(n, exp);
  endtask

  // Follows one primary frame: shape, end-of-data pulse, DAC load and the returned word.
  task automatic frame(input logic [15:0] txw, input bit byteM, input logic [15:0] rxExp);
    int n;
    runLen(1'b0, n);
    runLen(1'b1, n);
    runLen(1'b0, n);
    check(n, byteM ? 32 : 64);
    if (byteM) begin
      check(txEod, 1'b0);
      runLen(1'b1, n);
      check(n, 16);
      runLen(1'b0, n);
      check(n, 32);
    end
    tRise = $time;
    n = 0;
    while (txEod === 1'b0 && n < 100) begin
      @(posedge clk);
      #2;
      n++;
    end
    check(n, 4);
    repeat (2) @(posedge clk);
    #2;
    check(dacData, txw[15:2]);
    check(u_host.lastRx, rxExp);
  endtask

  // Follows the secondary frame that a primary with low bits 11 triggers.
  task automatic secondary(input logic [8:0] ctrlExp);
    int n;
    runLen(1'b1, n);
    check(($time - tRise) / 50, 16);
    check(rxSync, 1'b1);
    check(auxSync, dualWordMode ? 1'b0 : 1'b1);
    runLen(1'b0, n);
    check(n, 64);
    repeat (8) @(posedge clk);
    #2;
    check(u_host.lastRx, dualWordMode ? 16'hFFFF : 16'h0000);
    check(ctrl, ctrlExp);
  endtask

  // ----------------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------------
  task automatic resetValues();
    check(ctrl, 9'h039);
    check({txSync, rxSync, auxSync, txEod, rxEod}, 5'h1F);
    check(dacData, 14'h0000);
    period(0, 648);
    period(1, 648);
    period(3, 36);
  endtask

  task automatic wordAndByte();
    u_host.txQ.push_back(16'hABCC);
    frame(16'hABCC, 1'b0, 16'hA970);
    byteMode = 1'b1;
    u_host.txQ.push_back(16'h3C78);
    frame(16'h3C78, 1'b1, 16'hA970);
    byteMode = 1'b0;
  endtask

  // Loopback on and telephone routing, then a frame whose ADC word must echo the DAC word.
  task automatic controlAndLoop();
    dualWordMode = 1'b1;
    u_host.txQ.push_back(16'h1237);
    u_host.txQ.push_back(16'h066B);
    frame(16'h1237, 1'b0, 16'hA970);
    secondary(9'h0DA);
    dualWordMode = 1'b0;
    u_host.txQ.push_back(16'h5554);
    frame(16'h5554, 1'b0, 16'h1234);
  endtask

  // Receive side made independent, then given a longer B divider than transmit.
  task automatic asyncRates();
    u_host.txQ.push_back(16'h0003);
    u_host.txQ.push_back(16'h0007);
    frame(16'h0003, 1'b0, 16'h5554);
    secondary(9'h001);
    adcResult = 14'h1F03;
    u_host.txQ.push_back(16'h0003);
    u_host.txQ.push_back(16'h2452);
    frame(16'h0003, 1'b0, 16'h7C0C);
    secondary(9'h001);
    period(1, 720);
    period(2, 720);
    period(0, 648);
  endtask

  // Low bits 01 stretch the period after the next strobe by the reset adjust of one clock.
  task automatic adjustOnce();
    u_host.txQ.push_back(16'h0001);
    frame(16'h0001, 1'b0, 16'h7C0C);
    period(0, 649);
    period(0, 648);
  endtask

  // Clock enable low must freeze everything, so one period grows by exactly the frozen clocks.
  task automatic freezeRun();
    int n;
    logic [2:0] held;
    period(0, 648);
    n = 0;
    repeat (100) begin
      @(posedge clk);
      #2;
      n++;
    end
    ce = 1'b0;
    held = {shiftClk, dacFilterClk, txSync};
    repeat (42) begin
      @(posedge clk);
      #2;
      n++;
    end
    check({shiftClk, dacFilterClk, txSync}, held);
    ce = 1'b1;
    while (dacConvStrobe !== 1'b1 && n < 2000) begin
      @(posedge clk);
      #2;
      n++;
    end
    check(n, 690);
  endtask

  initial begin
    repeat (8) @(posedge clk);
    #2 sys_rst = 1'b0;
    resetValues();
    wordAndByte();
    controlAndLoop();
    asyncRates();
    adjustOnce();
    freezeRun();
    test_done();
  end

  // Whole run is about twenty conversion periods; this limit leaves ample room.
  initial begin
    #3000000;
    fail_count++;
    test_done();
  end
endmodule
